//--- hdl/tto_defines.svh
`ifndef TTO_DEFINES_SVH
`define TTO_DEFINES_SVH
// Register byte offsets
`define TTO_REG_CFG        8'h00
`define TTO_REG_UNIT       8'h04
`define TTO_REG_STATUS     8'h08
`define TTO_REG_ACTIVE     8'h0C
// Configuration word field positions
`define TTO_CFG_W          25
`define TTO_F_MAXSZ        0
`define TTO_F_RDR16        3
`define TTO_F_WRR16        4
`define TTO_F_PAR          5
`define TTO_F_RECOV        7
`define TTO_F_EOTC         8
`define TTO_F_SYNC         9
`define TTO_F_ID           10
`define TTO_F_LUNF         14
`define TTO_F_PFQ          15
`define TTO_F_STOP         17
`define TTO_F_HOLD         19
`define TTO_F_MEM          22
`define TTO_F_TMOEN        24
// Power-up: parity check, command timeout enabled
`define TTO_CFG_RST        25'h1000020
// Block length limits in bytes
`define TTO_BLK_32K        21'h008000
`define TTO_BLK_64K        21'h010000
`define TTO_BLK_128K       21'h020000
`define TTO_BLK_256K_SHORT 21'h03FEFF
`define TTO_BLK_256K       21'h040000
`define TTO_BLK_512K       21'h080000
`define TTO_BLK_1M         21'h100000
// Retry and parity limits
`define TTO_RETRY_LO       5'h08
`define TTO_RETRY_HI       5'h10
`define TTO_PAR_TRIES      2'h3
// Sense data
`define TTO_SK_RECOV       4'h1
`define TTO_SK_ABORT       4'hB
`define TTO_ASC_PARITY     8'h47
`define TTO_ASC_WR_REC     8'h0D
`define TTO_ASC_RD_REC     8'h17
`define TTO_ASC_IF_REC     8'h0E
`define TTO_ASCQ_00        8'h00
`define TTO_ASCQ_01        8'h01
// Buffered-write force timeout
`define TTO_FLUSH_MS       250
`define TTO_CLK_KHZ        20000
`endif

//--- hdl/tto_pkg.sv
package tto_pkg;
  typedef enum logic [1:0] {
    CMD_READ  = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_WFM   = 2'b10,
    CMD_OTHER = 2'b11
  } tto_cmd_t;
  typedef enum logic [1:0] {
    PAR_RETRY  = 2'b00,
    PAR_CHECK  = 2'b01,
    PAR_IGNORE = 2'b10
  } tto_par_t;
  typedef enum logic [2:0] {
    ACT_NONE     = 3'b000,
    ACT_READ_OPP = 3'b001,
    ACT_READ_ORG = 3'b010,
    ACT_BACKSP   = 3'b011,
    ACT_ERASE    = 3'b100,
    ACT_REWRITE  = 3'b101,
    ACT_REV_BUF  = 3'b110
  } tto_act_t;
  typedef enum logic [2:0] {
    RS_IDLE     = 3'b000,
    RS_RD_OPP   = 3'b001,
    RS_RD_ORG   = 3'b010,
    RS_WR_BACK  = 3'b011,
    RS_WR_ERASE = 3'b100,
    RS_WR_AGAIN = 3'b101
  } tto_rs_t;
endpackage : tto_pkg

//--- hdl/tto_policy.sv
// How it works
// - Reject blocks above selected maximum length
// - 256K memory caps block 257 bytes short
// - Read retry: opposite, then original direction
// - Reverse-recovered block is byte-reversed in buffer
// - Read retry count is 8 or 16
// - Write retry: backspace, erase, rewrite
// - Write retry count is 8 or 16
// - Parity retry: restore pointers, re-enter phase
// - Three parity tries, then bus free
// - Parity check reports sense B, 47 00
// - Parity ignore takes no action
// - Recovered errors use key 01 codes
// - Recovered error reporting can be suppressed
// - Stop or continue writes at end of tape
// - Inquiry byte 1 qualifier is selectable
// - Own synchronous negotiation can be disabled
// - Initiator synchronous negotiation always answered
// - Target ID 0 to 7 or unit number
// - Fixed LUN zero rejects LUNs 1-7
// - Unit-follow answers LUN equal to unit
// - Power-up forces timeout on, parity check
// - Prefetch disabled or after 1-3 reads
// - Prefetch stops after 1-3 filemarks, or never
// - Non-read command restarts read qualification
// - After filemark stop, requalify before prefetch
// - Buffered motion at block limit or timeout
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tto_defines.svh"
module tto_policy
  import tto_pkg::*;
#(
  parameter int FLUSH_CYC = `TTO_FLUSH_MS * `TTO_CLK_KHZ
)(
  // Clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  // Controller events
  input  wire  logic        bus_idle,
  input  wire  logic        cmd_valid,
  input  wire  tto_cmd_t    cmd_code,
  input  wire  logic [2:0]  cmd_lun,
  input  wire  logic [20:0] cmd_blk_len,
  input  wire  logic        end_of_tape_marker,
  input  wire  logic        select_event,
  input  wire  logic        sync_req_in,
  input  wire  logic        parity_err,
  input  wire  logic        parity_phase_ok,
  input  wire  logic        xfer_good,
  input  wire  logic        sense_clear,
  // Formatter events
  input  wire  logic        read_err,
  input  wire  logic        err_forward,
  input  wire  logic        write_err,
  input  wire  logic        op_ok,
  input  wire  logic        op_err,
  input  wire  logic        filemark_seen,
  input  wire  logic        block_stored,
  // Decisions
  output var   tto_act_t    tape_act,
  output var   logic        retry_fail,
  output var   logic        restore_ptr,
  output var   logic        phase_reenter,
  output var   logic        go_bus_free,
  output var   logic        blk_reject,
  output var   logic        lun_reject,
  output var   logic        write_stop,
  output var   logic        sync_start,
  output var   logic        sync_respond,
  output var   logic        prefetch_run,
  output var   logic        motion_start,
  output var   logic        force_flush,
  output var   logic        cmd_timeout_en,
  output var   logic [2:0]  bus_target_id_select,
  output var   logic [7:0]  inq_byte1,
  output var   logic        sense_valid,
  output var   logic [3:0]  sense_key,
  output var   logic [7:0]  sense_asc,
  output var   logic [7:0]  sense_ascq
);

  initial begin
    if (FLUSH_CYC < 1)
      $error("FLUSH_CYC must be at least one cycle");
  end

  typedef struct packed {
    logic [`TTO_CFG_W-1:0] cfg_stage;
    logic [`TTO_CFG_W-1:0] cfg_act;
    logic                  cfg_pend;
    logic [2:0]            unit_stage;
    logic [2:0]            unit_act;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    tto_rs_t               rs;
    logic [4:0]            rcnt;
    logic                  fwd;
    tto_act_t              act;
    logic                  retry_fail;
    logic [1:0]            pcnt;
    logic                  restore;
    logic                  reenter;
    logic                  busfree;
    logic                  blk_rej;
    logic                  lun_rej;
    logic                  wstop;
    logic                  sync_start;
    logic                  sync_resp;
    logic                  sync_done;
    logic [1:0]            rd_cnt;
    logic [1:0]            fm_cnt;
    logic                  pf_run;
    logic [4:0]            held;
    logic [31:0]           tmr;
    logic                  motion;
    logic                  flush;
    logic [2:0]            tgt_id;
    logic [7:0]            inq;
    logic                  sv;
    logic [3:0]            skey;
    logic [7:0]            asc;
    logic [7:0]            ascq;
  } tto_state_t;

  tto_state_t s_r;
  tto_state_t s_nxt;

  function automatic logic [20:0] tto_blk_limit(input logic [2:0] sel,
                                                input logic [1:0] mem);
    case (sel)
      3'd0:    tto_blk_limit = `TTO_BLK_32K;
      3'd1:    tto_blk_limit = `TTO_BLK_64K;
      3'd2:    tto_blk_limit = `TTO_BLK_128K;
      3'd3:    tto_blk_limit = (mem == 2'd0) ? `TTO_BLK_256K_SHORT
                                             : `TTO_BLK_256K;
      default: tto_blk_limit = (mem == 2'd0) ? `TTO_BLK_256K_SHORT :
                               (mem == 2'd1) ? `TTO_BLK_512K : `TTO_BLK_1M;
    endcase
  endfunction : tto_blk_limit

  function automatic logic [4:0] tto_retry_lim(input logic hi);
    tto_retry_lim = hi ? `TTO_RETRY_HI : `TTO_RETRY_LO;
  endfunction : tto_retry_lim

  // Recovered-error sense, only when reporting is enabled
  function automatic logic tto_report(input logic [`TTO_CFG_W-1:0] c);
    tto_report = c[`TTO_F_RECOV];
  endfunction : tto_report

  logic [`TTO_CFG_W-1:0] c;
  tto_par_t              par_mode;
  logic [4:0]            hold_lim;
  logic                  wr_access;
  assign c         = s_r.cfg_act;
  assign par_mode  = tto_par_t'(c[`TTO_F_PAR +: 2]);
  assign wr_access = psel && penable && s_r.pready && pwrite;
  assign hold_lim  = (c[`TTO_F_HOLD +: 3] > 3'd4) ? 5'h10
                   : 5'(5'h01 << c[`TTO_F_HOLD +: 3]);

  always_comb begin
    s_nxt            = s_r;
    s_nxt.pready     = 1'b0;
    s_nxt.pslverr    = 1'b0;
    s_nxt.act        = ACT_NONE;
    s_nxt.retry_fail = 1'b0;
    s_nxt.restore    = 1'b0;
    s_nxt.reenter    = 1'b0;
    s_nxt.busfree    = 1'b0;
    s_nxt.blk_rej    = 1'b0;
    s_nxt.lun_rej    = 1'b0;
    s_nxt.wstop      = 1'b0;
    s_nxt.sync_start = 1'b0;
    s_nxt.sync_resp  = 1'b0;
    s_nxt.motion     = 1'b0;
    s_nxt.flush      = 1'b0;

    // Staged options take effect only while the bus is free
    if (bus_idle && s_r.cfg_pend)
    begin
      s_nxt.cfg_act  = s_r.cfg_stage;
      s_nxt.unit_act = s_r.unit_stage;
      s_nxt.cfg_pend = 1'b0;
    end
    if (bus_idle)
    begin
      s_nxt.pcnt      = 2'd0;
      s_nxt.sync_done = 1'b0;
    end

    // APB: answer in the access cycle, zero wait states
    if (psel && !penable)
    begin
      s_nxt.pready = 1'b1;
      case (paddr)
        `TTO_REG_CFG:    s_nxt.prdata = 32'(s_r.cfg_stage);
        `TTO_REG_UNIT:   s_nxt.prdata = {29'h0, s_r.unit_stage};
        `TTO_REG_STATUS: s_nxt.prdata = {s_r.sv, 3'h0, s_r.skey, s_r.asc,
                                         s_r.ascq, s_r.pf_run, s_r.cfg_pend,
                                         s_r.tgt_id, s_r.rs};
        `TTO_REG_ACTIVE: s_nxt.prdata = 32'(s_r.cfg_act);
        default:
        begin
          s_nxt.prdata  = 32'h0;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_access && paddr == `TTO_REG_CFG)
    begin
      s_nxt.cfg_stage = pwdata[`TTO_CFG_W-1:0];
      s_nxt.cfg_stage[`TTO_F_TMOEN] = 1'b1;
      s_nxt.cfg_pend  = 1'b1;
    end
    if (wr_access && paddr == `TTO_REG_UNIT)
    begin
      s_nxt.unit_stage = pwdata[2:0];
      s_nxt.cfg_pend   = 1'b1;
    end
    if (sense_clear || (wr_access && paddr == `TTO_REG_STATUS && pwdata[31]))
      s_nxt.sv = 1'b0;

    // Identity and inquiry follow active options
    s_nxt.tgt_id = c[`TTO_F_ID + 3] ? s_r.unit_act
                                    : c[`TTO_F_ID +: 3];
    s_nxt.inq = (c[`TTO_F_ID +: 3] == 3'd0) ? 8'h00 :
                8'(8'h01 << (c[`TTO_F_ID +: 3] - 3'd1));

    // Negotiation
    if (select_event && c[`TTO_F_SYNC] && !s_r.sync_done)
    begin
      s_nxt.sync_start = 1'b1;
      s_nxt.sync_done  = 1'b1;
    end
    if (sync_req_in)
      s_nxt.sync_resp = 1'b1;

    // Command screening and read-ahead qualification
    if (cmd_valid)
    begin
      if (c[`TTO_F_LUNF] ? (cmd_lun != s_r.unit_act)
                         : (cmd_lun != 3'd0))
        s_nxt.lun_rej = 1'b1;
      else if (cmd_code != CMD_OTHER && cmd_code != CMD_WFM &&
               cmd_blk_len > tto_blk_limit(c[`TTO_F_MAXSZ +: 3],
                                           c[`TTO_F_MEM +: 2]))
        s_nxt.blk_rej = 1'b1;
      if ((cmd_code == CMD_WRITE || cmd_code == CMD_WFM) &&
          end_of_tape_marker && !c[`TTO_F_EOTC])
        s_nxt.wstop = 1'b1;
      if (cmd_code == CMD_READ)
      begin
        if (s_r.rd_cnt != 2'd3)
          s_nxt.rd_cnt = s_r.rd_cnt + 2'd1;
        if (c[`TTO_F_PFQ +: 2] != 2'd0 && !s_r.pf_run &&
            {1'b0, s_r.rd_cnt} + 3'd1 >= {1'b0, c[`TTO_F_PFQ +: 2]})
        begin
          s_nxt.pf_run = 1'b1;
          s_nxt.fm_cnt = 2'd0;
        end
      end
      else
      begin
        s_nxt.rd_cnt = 2'd0;
        s_nxt.pf_run = 1'b0;
      end
    end
    if (filemark_seen && s_r.pf_run)
    begin
      s_nxt.fm_cnt = s_r.fm_cnt + 2'd1;
      if (c[`TTO_F_STOP +: 2] != 2'd0 &&
          s_r.fm_cnt + 2'd1 >= c[`TTO_F_STOP +: 2])
      begin
        s_nxt.pf_run = 1'b0;
        s_nxt.rd_cnt = 2'd0;
      end
    end

    // Buffered write: start motion at the limit or on timeout
    if (block_stored)
    begin
      if (s_r.held + 5'd1 >= hold_lim)
      begin
        s_nxt.motion = 1'b1;
        s_nxt.held   = 5'd0;
        s_nxt.tmr    = 32'd0;
      end
      else
        s_nxt.held = s_r.held + 5'd1;
    end
    else if (s_r.held != 5'd0)
    begin
      if (s_r.tmr + 32'd1 >= 32'(FLUSH_CYC))
      begin
        s_nxt.flush = 1'b1;
        s_nxt.held  = 5'd0;
        s_nxt.tmr   = 32'd0;
      end
      else
        s_nxt.tmr = s_r.tmr + 32'd1;
    end

    // Interface parity
    if (parity_err && par_mode == PAR_RETRY && parity_phase_ok)
    begin
      if (s_r.pcnt == `TTO_PAR_TRIES)
        s_nxt.busfree = 1'b1;
      else
      begin
        s_nxt.restore = 1'b1;
        s_nxt.reenter = 1'b1;
        s_nxt.pcnt    = s_r.pcnt + 2'd1;
      end
    end
    if (xfer_good && s_r.pcnt != 2'd0 && tto_report(c))
    begin
      s_nxt.sv   = 1'b1;
      s_nxt.skey = `TTO_SK_RECOV;
      s_nxt.asc  = `TTO_ASC_IF_REC;
      s_nxt.ascq = `TTO_ASCQ_00;
    end
    if (parity_err && par_mode == PAR_CHECK)
    begin
      s_nxt.sv   = 1'b1;
      s_nxt.skey = `TTO_SK_ABORT;
      s_nxt.asc  = `TTO_ASC_PARITY;
      s_nxt.ascq = `TTO_ASCQ_00;
    end

    // Tape retry sequencer
    unique case (s_r.rs)
      RS_IDLE:
        if (read_err)
        begin
          s_nxt.rs   = RS_RD_OPP;
          s_nxt.act  = ACT_READ_OPP;
          s_nxt.fwd  = err_forward;
          s_nxt.rcnt = 5'd0;
        end
        else if (write_err)
        begin
          s_nxt.rs   = RS_WR_BACK;
          s_nxt.act  = ACT_BACKSP;
          s_nxt.rcnt = 5'd0;
        end
      RS_RD_OPP:
        if (op_ok)
        begin
          s_nxt.rs  = RS_IDLE;
          s_nxt.act = s_r.fwd ? ACT_REV_BUF : ACT_NONE;
          if (tto_report(c))
          begin
            s_nxt.sv   = 1'b1;
            s_nxt.skey = `TTO_SK_RECOV;
            s_nxt.asc  = `TTO_ASC_RD_REC;
            s_nxt.ascq = `TTO_ASCQ_01;
          end
        end
        else if (op_err)
        begin
          s_nxt.rs  = RS_RD_ORG;
          s_nxt.act = ACT_READ_ORG;
        end
      RS_RD_ORG:
        if (op_ok)
        begin
          s_nxt.rs = RS_IDLE;
          if (tto_report(c))
          begin
            s_nxt.sv   = 1'b1;
            s_nxt.skey = `TTO_SK_RECOV;
            s_nxt.asc  = `TTO_ASC_RD_REC;
            s_nxt.ascq = `TTO_ASCQ_01;
          end
        end
        else if (op_err)
        begin
          if (s_r.rcnt + 5'd1 >= tto_retry_lim(c[`TTO_F_RDR16]))
          begin
            s_nxt.rs         = RS_IDLE;
            s_nxt.retry_fail = 1'b1;
          end
          else
          begin
            s_nxt.rs   = RS_RD_OPP;
            s_nxt.act  = ACT_READ_OPP;
            s_nxt.rcnt = s_r.rcnt + 5'd1;
          end
        end
      RS_WR_BACK:
        if (op_ok)
        begin
          s_nxt.rs  = RS_WR_ERASE;
          s_nxt.act = ACT_ERASE;
        end
        else if (op_err)
        begin
          s_nxt.rs         = RS_IDLE;
          s_nxt.retry_fail = 1'b1;
        end
      RS_WR_ERASE:
        if (op_ok)
        begin
          s_nxt.rs  = RS_WR_AGAIN;
          s_nxt.act = ACT_REWRITE;
        end
        else if (op_err)
        begin
          s_nxt.rs         = RS_IDLE;
          s_nxt.retry_fail = 1'b1;
        end
      RS_WR_AGAIN:
        if (op_ok)
        begin
          s_nxt.rs = RS_IDLE;
          if (tto_report(c))
          begin
            s_nxt.sv   = 1'b1;
            s_nxt.skey = `TTO_SK_RECOV;
            s_nxt.asc  = `TTO_ASC_WR_REC;
            s_nxt.ascq = `TTO_ASCQ_01;
          end
        end
        else if (op_err)
        begin
          if (s_r.rcnt + 5'd1 >= tto_retry_lim(c[`TTO_F_WRR16]))
          begin
            s_nxt.rs         = RS_IDLE;
            s_nxt.retry_fail = 1'b1;
          end
          else
          begin
            s_nxt.rs   = RS_WR_BACK;
            s_nxt.act  = ACT_BACKSP;
            s_nxt.rcnt = s_r.rcnt + 5'd1;
          end
        end
      default:
        s_nxt.rs = RS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r           <= '0;
      s_r.cfg_stage <= `TTO_CFG_RST;
      s_r.cfg_act   <= `TTO_CFG_RST;
      s_r.rs        <= RS_IDLE;
      s_r.act       <= ACT_NONE;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata               = s_r.prdata;
  assign pready               = s_r.pready;
  assign pslverr              = s_r.pslverr;
  assign tape_act             = s_r.act;
  assign retry_fail           = s_r.retry_fail;
  assign restore_ptr          = s_r.restore;
  assign phase_reenter        = s_r.reenter;
  assign go_bus_free          = s_r.busfree;
  assign blk_reject           = s_r.blk_rej;
  assign lun_reject           = s_r.lun_rej;
  assign write_stop           = s_r.wstop;
  assign sync_start           = s_r.sync_start;
  assign sync_respond         = s_r.sync_resp;
  assign prefetch_run         = s_r.pf_run;
  assign motion_start         = s_r.motion;
  assign force_flush          = s_r.flush;
  assign cmd_timeout_en       = s_r.cfg_act[`TTO_F_TMOEN];
  assign bus_target_id_select = s_r.tgt_id;
  assign inq_byte1            = s_r.inq;
  assign sense_valid          = s_r.sv;
  assign sense_key            = s_r.skey;
  assign sense_asc            = s_r.asc;
  assign sense_ascq           = s_r.ascq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_rd_fail_back;
    s_r.rs == RS_RD_ORG && op_err && !op_ok;
  endsequence
  a_cfg_hold_busy: assert property (!bus_idle |=> $stable(s_r.cfg_act))
    else $error("active options changed during a transaction");
  a_lun_zero_rej: assert property (cmd_valid && !c[`TTO_F_LUNF] &&
    cmd_lun != 3'd0 |=> lun_reject)
    else $error("nonzero LUN not rejected");
  a_parity_bus_free: assert property (parity_err && parity_phase_ok &&
    par_mode == PAR_RETRY && s_r.pcnt == 2'd3 |=> go_bus_free && !restore_ptr)
    else $error("fourth parity error did not free the bus");
  a_parity_restore: assert property (restore_ptr |-> phase_reenter &&
    s_r.pcnt != 2'd0 && $past(par_mode) == PAR_RETRY)
    else $error("restore pointers without retry mode");
  a_parity_ignore: assert property (parity_err && par_mode == PAR_IGNORE &&
    !xfer_good |=> !restore_ptr && !go_bus_free)
    else $error("action taken on ignored parity");
  a_read_retry_seq: assert property (seq_rd_fail_back and
    s_r.rcnt == 5'd0 |=> tape_act == ACT_READ_OPP)
    else $error("read retry did not reverse again");
  a_timeout_locked: assert property (cmd_timeout_en)
    else $error("command timeout not enabled");
  a_sync_answer: assert property (sync_req_in |=> sync_respond)
    else $error("initiator negotiation not answered");
  a_flush_timeout: assert property (force_flush |->
    $past(s_r.held) != 5'd0 && $past(s_r.tmr) + 32'd1 >= 32'(FLUSH_CYC))
    else $error("force flush before timeout");

endmodule : tto_policy
`default_nettype wire

//--- sim/tto_fmt_model.sv
`timescale 1ns/10ps
`default_nettype none
module tto_fmt_model
  import tto_pkg::*;
(
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // Failure script
  input  wire logic     clear,
  input  wire integer   n_bad,
  // Formatter side
  input  wire tto_act_t tape_act,
  output var  logic     op_ok,
  output var  logic     op_err
);
  int used_r;
  int dly_r;

  // Answers each tape action except ACT_REV_BUF a few cycles later; the first n_bad fail
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      used_r <= 0;
      dly_r  <= 0;
      op_ok  <= 1'b0;
      op_err <= 1'b0;
    end
    else
    begin
      op_ok  <= 1'b0;
      op_err <= 1'b0;
      if (clear)
        used_r <= 0;
      if (tape_act != ACT_NONE && tape_act != ACT_REV_BUF)
        dly_r <= 3;
      else if (dly_r != 0)
        dly_r <= dly_r - 1;
      if (dly_r == 1 && used_r < n_bad)
      begin
        op_err <= 1'b1;
        used_r <= used_r + 1;
      end
      else if (dly_r == 1)
        op_ok <= 1'b1;
    end
  end
endmodule : tto_fmt_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tto_defines.svh"
module tb
  import tto_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, inq_byte1, sense_asc, sense_ascq;
  logic [31:0] pwdata, prdata, r;
  logic        bus_idle, cmd_valid, end_of_tape_marker, select_event;
  logic        sync_req_in, parity_err, parity_phase_ok, xfer_good;
  logic        sense_clear, read_err, err_forward, write_err, op_ok;
  logic        op_err, filemark_seen, block_stored, retry_fail;
  logic        restore_ptr, phase_reenter, go_bus_free, blk_reject;
  logic        lun_reject, write_stop, sync_start, sync_respond;
  logic        prefetch_run, motion_start, force_flush, cmd_timeout_en;
  logic        sense_valid, clear, perr;
  logic [3:0]  sense_key;
  logic [2:0]  cmd_lun, bus_target_id_select;
  logic [20:0] cmd_blk_len;
  tto_cmd_t    cmd_code;
  tto_act_t    tape_act;
  int          n_bad, n_fail, n_compared, k;
  int          cnt [12];

  tto_policy #(.FLUSH_CYC(50)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_idle,
    .cmd_valid, .cmd_code, .cmd_lun, .cmd_blk_len, .end_of_tape_marker,
    .select_event, .sync_req_in, .parity_err, .parity_phase_ok, .xfer_good,
    .sense_clear, .read_err, .err_forward, .write_err, .op_ok, .op_err,
    .filemark_seen, .block_stored, .tape_act, .retry_fail, .restore_ptr,
    .phase_reenter, .go_bus_free, .blk_reject, .lun_reject, .write_stop,
    .sync_start, .sync_respond, .prefetch_run, .motion_start, .force_flush,
    .cmd_timeout_en, .bus_target_id_select, .inq_byte1, .sense_valid,
    .sense_key, .sense_asc, .sense_ascq);
  tto_fmt_model fmt (.pclk, .presetn, .clear, .n_bad, .tape_act, .op_ok,
    .op_err);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Pulse tallies sampled on each rising edge
  always @(posedge pclk)
  begin
    cnt[0] <= cnt[0] + blk_reject;
    cnt[1] <= cnt[1] + lun_reject;
    cnt[2] <= cnt[2] + restore_ptr;
    cnt[3] <= cnt[3] + go_bus_free;
    cnt[4] <= cnt[4] + retry_fail;
    cnt[5] <= cnt[5] + (tape_act != ACT_NONE);
    cnt[6]  <= cnt[6] + sync_start;
    cnt[7]  <= cnt[7] + sync_respond;
    cnt[8]  <= cnt[8] + write_stop;
    cnt[9]  <= cnt[9] + motion_start;
    cnt[10] <= cnt[10] + force_flush;
    cnt[11] <= cnt[11] + (tape_act == ACT_REV_BUF);
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r    = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic setcfg(input logic [31:0] d);
    apb(1'b1, `TTO_REG_CFG, d);
    bus_idle <= 1'b1;
    @(posedge pclk);
    bus_idle <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : setcfg

  task automatic cmd(input tto_cmd_t c, input logic [2:0] l,
                     input logic [20:0] n);
    cmd_valid   <= 1'b1;
    cmd_code    <= c;
    cmd_lun     <= l;
    cmd_blk_len <= n;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : cmd

  task automatic sense(input logic [31:0] exp);
    apb(1'b0, `TTO_REG_STATUS, 32'h0);
    chk(r & 32'hFFFFFF00, exp);
    chk({sense_valid, 3'h0, sense_key, sense_asc, sense_ascq, 8'h00}, exp);
  endtask : sense

  task automatic results;
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, bus_idle, cmd_valid} = '0;
    {end_of_tape_marker, select_event, sync_req_in, parity_err} = '0;
    {parity_phase_ok, xfer_good, sense_clear, read_err} = '0;
    {err_forward, write_err, filemark_seen, block_stored} = '0;
    {cmd_lun, cmd_blk_len, clear, presetn} = '0;
    cmd_code = CMD_OTHER;
    cnt = '{default: 0};
    {n_bad, n_fail, n_compared} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TTO_REG_CFG, 32'h0);
    chk(r, 32'h01000020);
    chk({31'h0, cmd_timeout_en}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // Retry parity, report recovered, 32K limit, ID 5, fixed LUN 0
    setcfg(32'h00001480);
    chk({29'h0, bus_target_id_select}, 32'h5);
    chk({24'h0, inq_byte1}, 32'h10);
    cmd(CMD_READ, 3'h0, `TTO_BLK_32K);
    cmd(CMD_READ, 3'h0, `TTO_BLK_32K + 21'h1);
    chk(cnt[0], 1);
    cmd(CMD_WRITE, 3'h1, 21'h10);
    chk(cnt[1], 1);
    parity_phase_ok <= 1'b1;
    repeat (4)
    begin
      parity_err <= 1'b1;
      @(posedge pclk);
      parity_err <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    chk(cnt[2], 3);
    chk(cnt[3], 1);
    n_bad       <= 1;
    err_forward <= 1'b1;
    read_err    <= 1'b1;
    @(posedge pclk);
    read_err <= 1'b0;
    repeat (30) @(posedge pclk);
    sense(32'h81170100);
    write_err <= 1'b1;
    @(posedge pclk);
    write_err <= 1'b0;
    repeat (30) @(posedge pclk);
    sense(32'h810D0100);
    k = cnt[5];
    clear       <= 1'b1;
    n_bad       <= 99;
    err_forward <= 1'b0;
    read_err    <= 1'b1;
    @(posedge pclk);
    {clear, read_err} <= 2'b00;
    repeat (300) @(posedge pclk);
    chk(cnt[4], 1);
    chk(cnt[5] - k, 16);
    // Parity check, own sync, hold 2, prefetch after 1 read, stop on 1 mark
    setcfg(32'h000A8220);
    parity_err <= 1'b1;
    @(posedge pclk);
    parity_err <= 1'b0;
    repeat (3) @(posedge pclk);
    sense(32'h8B470000);
    {select_event, sync_req_in} <= 2'b11;
    @(posedge pclk);
    {select_event, sync_req_in} <= 2'b00;
    repeat (2) @(posedge pclk);
    chk(cnt[6], 1);
    chk(cnt[7], 1);
    end_of_tape_marker <= 1'b1;
    cmd(CMD_WFM, 3'h0, 21'h0);
    chk(cnt[8], 1);
    end_of_tape_marker <= 1'b0;
    cmd(CMD_READ, 3'h0, 21'h10);
    chk({31'h0, prefetch_run}, 32'h1);
    filemark_seen <= 1'b1;
    @(posedge pclk);
    filemark_seen <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, prefetch_run}, 32'h0);
    cmd(CMD_READ, 3'h0, 21'h10);
    chk({31'h0, prefetch_run}, 32'h1);
    cmd(CMD_OTHER, 3'h0, 21'h0);
    chk({31'h0, prefetch_run}, 32'h0);
    repeat (3)
    begin
      block_stored <= 1'b1;
      @(posedge pclk);
      block_stored <= 1'b0;
      @(posedge pclk);
    end
    repeat (60) @(posedge pclk);
    chk(cnt[9], 1);
    chk(cnt[10], 1);
    clear       <= 1'b1;
    n_bad       <= 0;
    err_forward <= 1'b1;
    read_err    <= 1'b1;
    @(posedge pclk);
    {clear, read_err} <= 2'b00;
    repeat (30) @(posedge pclk);
    chk(cnt[11], 1);
    sense(32'h8B470000);
    results;
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    results;
  end
endmodule : tb
`default_nettype wire
